// File: common/qdc_frame_if.sv
// Frame hand-over between the serial receiver and the decoder
`timescale 1ns/1ns
interface qdc_frame_if;
  logic               valid;
  qdc_pkg::qdc_frame_t frame;
  modport rx (output valid, output frame);
  modport dec (input valid, input frame);
endinterface

// File: common/qdc_map.svh
// Constants for the quad DAC command decoder
`ifndef QDC_MAP_SVH
`define QDC_MAP_SVH
`define QDC_FRAME_BITS     24
`define QDC_CMD_HI         21
`define QDC_CMD_LO         19
`define QDC_ADDR_HI        18
`define QDC_ADDR_LO        16
`define QDC_DATA_HI        15
`define QDC_MODE_HI        5
`define QDC_MODE_LO        4
`define QDC_SEL_HI         3
`define QDC_RST_BIT        0
`define QDC_REF_BIT        0
`define QDC_CMD_WR_IN      3'h0
`define QDC_CMD_UPD        3'h1
`define QDC_CMD_WR_ALL     3'h2
`define QDC_CMD_WR_UPD     3'h3
`define QDC_CMD_POWER      3'h4
`define QDC_CMD_RESET      3'h5
`define QDC_CMD_MASK       3'h6
`define QDC_CMD_REF        3'h7
`define QDC_ADDR_ALL       3'h7
`define QDC_MODE_NORMAL    2'h0
`define QDC_MASK_RST       4'h0
`define QDC_REF_RST        1'h0
`define QDC_WAKE_NS        4000
`define QDC_CLK_NS         4
`define QDC_CNT_W          10
`endif

// File: common/qdc_pkg.sv
// Types for the quad DAC command decoder
package qdc_pkg;
  typedef logic [23:0] qdc_frame_t;
  typedef logic [1:0]  qdc_mode_t;
endpackage

// File: hw/qdc_serial_rx.sv
// Serial receiver: synchronises the pins and assembles 24-bit frames
`timescale 1ns/1ns
`include "qdc_map.svh"
module qdc_serial_rx (
  input  wire logic   clk_i,
  input  wire logic   arst_n_i,
  input  wire logic   frame_sel_n_i,
  input  wire logic   sclk_i,
  input  wire logic   sdata_i,
  input  wire logic   flush_i,
  qdc_frame_if.rx     fr
);
  typedef struct packed {
    logic [1:0]  sel_s;
    logic [1:0]  clk_s;
    logic [1:0]  dat_s;
    logic        clk_d;
    logic        done;
    logic [4:0]  cnt;
    logic [23:0] shift;
    logic        valid;
    logic [23:0] frame;
  } qdc_rx_s;
  qdc_rx_s s_reg;
  qdc_rx_s s_next;
  always_comb begin
    s_next       = s_reg;
    s_next.sel_s = {s_reg.sel_s[0], frame_sel_n_i};
    s_next.clk_s = {s_reg.clk_s[0], sclk_i};
    s_next.dat_s = {s_reg.dat_s[0], sdata_i};
    s_next.clk_d = s_reg.clk_s[1];
    s_next.valid = 1'b0;
    if (s_reg.sel_s[1] || flush_i) begin
      // Frame select high: abort a partial frame and clear the shifter
      s_next.cnt   = 5'h0;
      s_next.shift = 24'h0;
      s_next.done  = 1'b0;
    end else if (s_reg.clk_d && !s_reg.clk_s[1] && !s_reg.done) begin
      // Falling edge, MSB first
      s_next.shift = {s_reg.shift[22:0], s_reg.dat_s[1]};
      if (s_reg.cnt == 5'(`QDC_FRAME_BITS - 1)) begin
        s_next.valid = 1'b1;
        s_next.frame = {s_reg.shift[22:0], s_reg.dat_s[1]};
        s_next.done  = 1'b1;
        s_next.cnt   = 5'h0;
      end else begin
        s_next.cnt = s_reg.cnt + 5'h1;
      end
    end
  end
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      s_reg <= '{sel_s: 2'h3, clk_s: 2'h0, dat_s: 2'h0, clk_d: 1'b0, done: 1'b0,
                 cnt: 5'h0, shift: 24'h0, valid: 1'b0, frame: 24'h0};
    end else begin
      s_reg <= s_next;
    end
  end
  assign fr.valid = s_reg.valid;
  assign fr.frame = s_reg.frame;
endmodule

// File: hw/qdc_top.sv
// Quad DAC command decoder: serial frames to input, DAC and mode state
`timescale 1ns/1ns
`include "qdc_map.svh"
module qdc_top #(
  parameter int CHANNELS = 4,
  parameter int CODE_W   = 16
) (
  input  wire logic                clk_i,
  input  wire logic                arst_n_i,
  input  wire logic                frame_sel_n_i,
  input  wire logic                sclk_i,
  input  wire logic                sdata_i,
  output logic [CHANNELS*CODE_W-1:0] dac_code_o,
  output logic [CHANNELS*2-1:0]    power_mode_o,
  output logic [CHANNELS-1:0]      amp_connect_o,
  output logic [CHANNELS-1:0]      out_settled_o,
  output logic [CHANNELS-1:0]      sync_mask_o,
  output logic                     reference_output_o
);
  initial begin
    if (CHANNELS != 4 || CODE_W < 1 || CODE_W > 16) begin
      $error("qdc_top: unsupported CHANNELS or CODE_W");
    end
  end
  qdc_frame_if fr ();
  typedef struct packed {
    logic [CHANNELS-1:0][CODE_W-1:0] in_r;
    logic [CHANNELS-1:0][CODE_W-1:0] dac_r;
    logic [CHANNELS-1:0][1:0]        mode;
    logic [CHANNELS-1:0]             amp;
    logic [CHANNELS-1:0]             mask;
    logic                            ref_en;
    logic                            flush;
  } qdc_top_s;
  qdc_top_s s_reg;
  qdc_top_s s_next;
  logic [2:0]        cmd;
  logic [2:0]        addr;
  logic [15:0]       data;
  logic [CODE_W-1:0] code;
  logic [CHANNELS-1:0] wake;
  logic [CHANNELS-1:0] sleep;
  logic [CHANNELS-1:0] settled;
  assign cmd  = fr.frame[`QDC_CMD_HI:`QDC_CMD_LO];
  assign addr = fr.frame[`QDC_ADDR_HI:`QDC_ADDR_LO];
  assign data = fr.frame[`QDC_DATA_HI:0];
  // Code is left-justified; narrower parts drop the trailing don't-care bits
  assign code = data[15 -: CODE_W];
  qdc_serial_rx u_rx (
    .clk_i         (clk_i),
    .arst_n_i      (arst_n_i),
    .frame_sel_n_i (frame_sel_n_i),
    .sclk_i        (sclk_i),
    .sdata_i       (sdata_i),
    .flush_i       (s_reg.flush),
    .fr            (fr)
  );
  always_comb begin
    s_next       = s_reg;
    s_next.flush = 1'b0;
    wake         = '0;
    sleep        = '0;
    if (fr.valid) begin
      case (cmd)
        `QDC_CMD_WR_IN, `QDC_CMD_WR_ALL, `QDC_CMD_WR_UPD: begin
          for (int i = 0; i < CHANNELS; i++) begin
            if (addr == `QDC_ADDR_ALL || addr == 3'(i)) begin
              s_next.in_r[i] = code;
            end
          end
          for (int i = 0; i < CHANNELS; i++) begin
            if (cmd == `QDC_CMD_WR_ALL) begin
              s_next.dac_r[i] = s_next.in_r[i];
            end else if (cmd == `QDC_CMD_WR_UPD &&
                         (addr == `QDC_ADDR_ALL || addr == 3'(i))) begin
              s_next.dac_r[i] = s_next.in_r[i];
            end else if (s_reg.mask[i]) begin
              s_next.dac_r[i] = s_next.in_r[i];
            end
            // Unmasked channel under 000 keeps its DAC value
          end
        end
        `QDC_CMD_UPD: begin
          for (int i = 0; i < CHANNELS; i++) begin
            if (addr == `QDC_ADDR_ALL || addr == 3'(i)) begin
              s_next.dac_r[i] = s_reg.in_r[i];
            end
          end
        end
        `QDC_CMD_POWER: begin
          for (int i = 0; i < CHANNELS; i++) begin
            if (data[`QDC_SEL_HI - (CHANNELS - 1) + i]) begin
              s_next.mode[i] = data[`QDC_MODE_HI:`QDC_MODE_LO];
              s_next.amp[i]  = (data[`QDC_MODE_HI:`QDC_MODE_LO] == `QDC_MODE_NORMAL);
              if (s_next.amp[i] && !s_reg.amp[i]) begin
                wake[i] = 1'b1;
              end
              if (!s_next.amp[i]) begin
                sleep[i] = 1'b1;
              end
            end
          end
          // DAC registers untouched here
        end
        `QDC_CMD_RESET: begin
          s_next.dac_r = '0;
          s_next.flush = 1'b1;
          if (data[`QDC_RST_BIT]) begin
            s_next.mask   = `QDC_MASK_RST;
            s_next.ref_en = `QDC_REF_RST;
            for (int i = 0; i < CHANNELS; i++) begin
              s_next.mode[i] = `QDC_MODE_NORMAL;
              s_next.amp[i]  = 1'b1;
              wake[i]        = !s_reg.amp[i];
            end
          end
        end
        `QDC_CMD_MASK: begin
          s_next.mask = data[`QDC_SEL_HI:0];
        end
        `QDC_CMD_REF: begin
          s_next.ref_en = data[`QDC_REF_BIT];
        end
        default: begin
          s_next = s_reg;
        end
      endcase
    end
  end
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      s_reg <= '{in_r: '0, dac_r: '0, mode: '0, amp: '1,
                 mask: `QDC_MASK_RST, ref_en: `QDC_REF_RST, flush: 1'b0};
    end else begin
      s_reg <= s_next;
    end
  end
  genvar g;
  generate
    for (g = 0; g < CHANNELS; g++) begin : g_wake
      qdc_wake_timer u_wt (
        .clk_i     (clk_i),
        .arst_n_i  (arst_n_i),
        .start_i   (wake[g]),
        .stop_i    (sleep[g]),
        .settled_o (settled[g])
      );
    end
  endgenerate
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      dac_code_o         <= '0;
      power_mode_o       <= '0;
      amp_connect_o      <= '1;
      out_settled_o      <= '1;
      sync_mask_o        <= '0;
      reference_output_o <= 1'b0;
    end else begin
      dac_code_o         <= s_reg.dac_r;
      power_mode_o       <= s_reg.mode;
      amp_connect_o      <= s_reg.amp;
      out_settled_o      <= settled & s_reg.amp;
      sync_mask_o        <= s_reg.mask;
      reference_output_o <= s_reg.ref_en;
    end
  end
endmodule

// File: hw/qdc_wake_timer.sv
// Per-channel settling timer after leaving power-down
`timescale 1ns/1ns
`include "qdc_map.svh"
module qdc_wake_timer #(
  parameter int CNT_W = `QDC_CNT_W,
  parameter int WAKE_CYCLES = `QDC_WAKE_NS / `QDC_CLK_NS
) (
  input  wire logic clk_i,
  input  wire logic arst_n_i,
  input  wire logic start_i,
  input  wire logic stop_i,
  output logic      settled_o
);
  initial begin
    if (WAKE_CYCLES < 1 || WAKE_CYCLES >= (1 << CNT_W)) begin
      $error("qdc_wake_timer: WAKE_CYCLES out of range");
    end
  end
  typedef struct packed {
    logic [CNT_W-1:0] cnt;
    logic             settled;
  } qdc_wt_s;
  qdc_wt_s s_reg;
  qdc_wt_s s_next;
  always_comb begin
    s_next = s_reg;
    if (stop_i) begin
      s_next.cnt     = '0;
      s_next.settled = 1'b0;
    end else if (start_i) begin
      s_next.cnt     = CNT_W'(WAKE_CYCLES);
      s_next.settled = 1'b0;
    end else if (s_reg.cnt != '0) begin
      s_next.cnt = s_reg.cnt - 1'b1;
      s_next.settled = (s_reg.cnt == CNT_W'(1));
    end
  end
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      s_reg <= '{cnt: '0, settled: 1'b1};
    end else begin
      s_reg <= s_next;
    end
  end
  assign settled_o = s_reg.settled;
endmodule

// File: tb/qdc_assertions.sv
// Concurrent checks on the quad DAC decoder ports
`timescale 1ns/1ns
module qdc_assertions #(
  parameter int CHANNELS = 4,
  parameter int CODE_W   = 16
) (
  input wire logic                       clk_i,
  input wire logic                       arst_n_i,
  input wire logic                       frame_sel_n_i,
  input wire logic                       sclk_i,
  input wire logic                       sdata_i,
  input wire logic [CHANNELS*CODE_W-1:0] dac_code_o,
  input wire logic [CHANNELS*2-1:0]      power_mode_o,
  input wire logic [CHANNELS-1:0]        amp_connect_o,
  input wire logic [CHANNELS-1:0]        out_settled_o,
  input wire logic [CHANNELS-1:0]        sync_mask_o,
  input wire logic                       reference_output_o
);
  logic [3:0]          fall_cnt_reg;
  logic [10:0]         wake_cnt_reg;
  logic [CHANNELS-1:0] norm;
  logic                at_end;
  default clocking @(posedge clk_i); endclocking
  default disable iff (!arst_n_i);
  always_comb
    for (int i = 0; i < CHANNELS; i++) norm[i] = (power_mode_o[2*i +: 2] == 2'h0);
  // Outputs other than out_settled_o may only move a few cycles after a serial clock fall
  assign at_end = fall_cnt_reg inside {[4'h2:4'h7]};
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      fall_cnt_reg <= 4'hf;
      wake_cnt_reg <= 11'h0;
    end else begin
      fall_cnt_reg <= $fell(sclk_i) ? 4'h0 : fall_cnt_reg + {3'h0, fall_cnt_reg != 4'hf};
      wake_cnt_reg <= (amp_connect_o[0] && !out_settled_o[0]) ? wake_cnt_reg + 11'h1 : 11'h0;
    end
  end
  sequence wake_low_s;
    ##[0:2] !out_settled_o[0] ##1 !out_settled_o[0] [*4];
  endsequence
  amp_match_a: assert property (amp_connect_o == norm)
    else $error("amp connect disagrees with power mode");
  code_time_a: assert property ($changed(dac_code_o) |-> at_end)
    else $error("DAC code changed away from frame end");
  mode_time_a: assert property ($changed(power_mode_o) |-> at_end)
    else $error("power mode changed away from frame end");
  mask_time_a: assert property (!at_end |-> $stable(sync_mask_o))
    else $error("sync mask changed away from frame end");
  ref_time_a: assert property (!at_end |-> $stable(reference_output_o))
    else $error("reference enable changed away from frame end");
  wake_drop_a: assert property ($rose(amp_connect_o[0]) |-> wake_low_s)
    else $error("channel A settled too early after power-up");
  wake_len_a: assert property (wake_cnt_reg <= 11'h3ea)
    else $error("channel A settle interval too long");
  settle_cause_a: assert property ($fell(out_settled_o[0]) |-> $fell(amp_connect_o[0]))
    else $error("settle dropped without a power-down of channel A");
endmodule

// File: tb/qdc_host_model.sv
// Serial host model that shifts frames into the decoder
`timescale 1ns/1ns
module qdc_host_model (
  input  wire logic clk_i,
  output logic      frame_sel_n_o,
  output logic      sclk_o,
  output logic      sdata_o
);
  localparam int HALF_NS = 40;
  initial begin
    frame_sel_n_o = 1'b1;
    sclk_o        = 1'b1;
    sdata_o       = 1'b0;
  end
  // Sends the first n bits; fewer than 24 abandons the frame
  task automatic send(input logic [23:0] f, input int n);
    @(posedge clk_i);
    #1;
    frame_sel_n_o = 1'b0;
    for (int i = 0; i < n; i++) begin
      sdata_o = f[23-i];
      #HALF_NS sclk_o = 1'b0;
      #HALF_NS sclk_o = 1'b1;
    end
    // Released data line must not keep the last bit
    sdata_o = ~sdata_o;
    #HALF_NS frame_sel_n_o = 1'b1;
    #(2*HALF_NS);
  endtask
endmodule

// File: tb/tb_top.sv
// Self-checking bench for the quad DAC command decoder
`timescale 1ns/1ns
module tb_top;
  localparam logic [80:0] RST = {72'h0, 4'hf, 4'h0, 1'h0};
  logic             clk_i = 1'b0;
  logic             arst_n_i = 1'b0;
  logic             frame_sel_n, sclk, sdata, reference_output_o;
  logic [63:0]      dac_code_o;
  logic [7:0]       power_mode_o;
  logic [3:0]       amp_connect_o, out_settled_o, sync_mask_o;
  logic [3:0][15:0] minp = '0;
  logic [3:0][15:0] mdac = '0;
  logic [3:0][1:0]  mpm = '0;
  logic [3:0]       mmask = '0;
  logic             mref = 1'b0;
  logic [80:0]      snap, last = RST, prev = RST;
  logic [80:0]      expq[$];
  int               failures = 0;
  int               checks = 0;
  int               seed = 94;
  always #2 clk_i = ~clk_i;
  qdc_top uut (.clk_i(clk_i), .arst_n_i(arst_n_i), .frame_sel_n_i(frame_sel_n),
    .sclk_i(sclk), .sdata_i(sdata), .dac_code_o(dac_code_o), .power_mode_o(power_mode_o),
    .amp_connect_o(amp_connect_o), .out_settled_o(out_settled_o),
    .sync_mask_o(sync_mask_o), .reference_output_o(reference_output_o));
  qdc_host_model u_host (.clk_i(clk_i), .frame_sel_n_o(frame_sel_n), .sclk_o(sclk),
    .sdata_o(sdata));
  task automatic final_report();
    $display("checks=%0d failures=%0d", checks, failures);
    if (failures == 0 && checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic check(input logic [80:0] seen, input logic [80:0] exp);
    checks++;
    if (seen !== exp) begin
      failures++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  function automatic logic [80:0] mview();
    logic [3:0] amp;
    for (int i = 0; i < 4; i++) amp[i] = (mpm[i] == 2'h0);
    return {mdac, mpm, amp, mmask, mref};
  endfunction
  task automatic frame(input logic [23:0] f, input int n);
    logic [2:0]  c, a;
    logic [15:0] d;
    logic [80:0] nxt;
    {c, a, d} = f[21:0];
    if (n == 24) begin
      for (int i = 0; i < 4; i++) begin
        if (c inside {3'h0, 3'h2, 3'h3}) begin
          if (a == 3'(i) || a == 3'h7) minp[i] = d;
          if (c == 3'h2 || mmask[i] || (c == 3'h3 && (a == 3'(i) || a == 3'h7)))
            mdac[i] = minp[i];
        end
        if (c == 3'h1 && (a == 3'(i) || a == 3'h7)) mdac[i] = minp[i];
        if (c == 3'h4 && d[i]) mpm[i] = d[5:4];
      end
      if (c == 3'h5) begin
        mdac = '0;
        if (d[0]) {mmask, mpm, mref} = '0;
      end
      if (c == 3'h6) mmask = d[3:0];
      if (c == 3'h7) mref = d[0];
      nxt = mview();
      if (nxt !== prev) expq.push_back(nxt);
      prev = nxt;
    end
    u_host.send(f, n);
  endtask
  // Outputs are looked at mid-cycle, well away from the edge that launches them
  always @(negedge clk_i) begin
    snap = {dac_code_o, power_mode_o, amp_connect_o, sync_mask_o, reference_output_o};
    if (arst_n_i && snap !== last) begin
      if (expq.size() == 0) check(snap, ~snap);
      else check(snap, expq.pop_front());
      last = snap;
    end
  end
  initial begin
    #380000;
    failures++;
    final_report();
  end
  initial begin
    repeat (5) @(posedge clk_i);
    #1 arst_n_i = 1'b1;
    repeat (2) @(posedge clk_i);
    #1 check(snap, RST);
    for (int c = 0; c < 8; c++) frame({2'h3, 3'(c), 3'h7, 16'h5a3d}, 24);
    frame({2'h0, 3'h7, 3'h0, 16'h0000}, 1 + ($unsigned($random(seed)) % 23));
    frame({2'h0, 3'h4, 3'h0, 16'h0011}, 24);
    frame({2'h0, 3'h4, 3'h0, 16'h0001}, 24);
    check(81'(out_settled_o[0]), 81'h0);
    for (int k = 0; k < 2000 && out_settled_o[0] !== 1'b1; k++) @(posedge clk_i);
    check(81'(out_settled_o[0]), 81'h1);
    check(81'(out_settled_o), 81'hf);
    repeat (50) frame(24'($random(seed)), 24);
    repeat (20) @(posedge clk_i);
    check(81'(expq.size()), 81'h0);
    final_report();
  end
endmodule
bind qdc_top qdc_assertions #(.CHANNELS(CHANNELS), .CODE_W(CODE_W)) u_chk (
  .clk_i(clk_i), .arst_n_i(arst_n_i), .frame_sel_n_i(frame_sel_n_i), .sclk_i(sclk_i),
  .sdata_i(sdata_i), .dac_code_o(dac_code_o), .power_mode_o(power_mode_o),
  .amp_connect_o(amp_connect_o), .out_settled_o(out_settled_o),
  .sync_mask_o(sync_mask_o), .reference_output_o(reference_output_o));
